// >>> src/srg_pkg.sv
package srg_pkg;

	// clock rate and the indication period
	localparam int unsigned CLK_HZ         = 100_000_000;
	localparam int unsigned IND_HZ         = 1;
	localparam int unsigned IND_HALF_CYC   = CLK_HZ / (2 * IND_HZ);
	localparam int unsigned IND_CNT_W      = 26;

	// gating input count limits
	localparam int unsigned NUM_IN_MIN     = 2;
	localparam int unsigned NUM_IN_MAX     = 8;
	localparam int unsigned OPT_IN_MAX     = NUM_IN_MAX - 2;

	// register map, byte addresses
	localparam logic [7:0]  ADDR_CTRL      = 8'h00;
	localparam logic [7:0]  ADDR_STATUS    = 8'h04;

	// control field positions
	localparam int unsigned CTRL_EDGE_BIT  = 0;
	localparam int unsigned CTRL_SREL_BIT  = 1;
	localparam int unsigned CTRL_IND_BIT   = 2;
	localparam int unsigned CTRL_NIN_LSB   = 4;
	localparam int unsigned CTRL_NIN_W     = 4;

	// status field positions
	localparam int unsigned STAT_EN_BIT    = 0;
	localparam int unsigned STAT_SREL_BIT  = 1;
	localparam int unsigned STAT_IND_BIT   = 2;
	localparam int unsigned STAT_ARM_BIT   = 3;
	localparam int unsigned STAT_IN_LSB    = 8;

	// reset values: low-high-low, both optional outputs off, two inputs
	localparam logic        CTRL_EDGE_RST  = 1'b0;
	localparam logic        CTRL_SREL_RST  = 1'b0;
	localparam logic        CTRL_IND_RST   = 1'b0;
	localparam logic [3:0]  CTRL_NIN_RST   = 4'h2;

	// reset recognition state
	typedef enum logic [1:0] {
		SRG_IDLE,
		SRG_HIGH_SEEN,
		SRG_ENABLED
	} srg_state_e;

endpackage : srg_pkg

// >>> src/srg_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a vector of pins
module srg_sync #(
	parameter int unsigned W = 8
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rstn,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q; // first stage, read only by q
	logic [W-1:0] meta_d;
	logic [W-1:0] q_d;

	// next values
	always_comb begin
		meta_d = d;
		q_d    = meta_q;
	end

	// registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= meta_d;
			q      <= q_d;
		end
	end

endmodule : srg_sync

// >>> src/srg_gate.sv
`timescale 1ns/1ps
module srg_gate
	import srg_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// gating pins: monitored input, optional inputs, reset switch
	input  wire logic        mon_in,
	input  wire logic [5:0]  opt_in,
	input  wire logic        rst_sw,
	// gate outputs
	output logic             out_en,
	output logic             static_rel,
	output logic             rst_req_ind,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp
);
	import srg_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [7:0] pins_s;    // {rst_sw, opt_in, mon_in} after two flops
	srg_sync #(.W(8)) u_sync (
		.mclk (mclk),
		.rstn (rstn),
		.d    ({rst_sw, opt_in, mon_in}),
		.q    (pins_s)
	);

	logic       mon_s;
	logic [5:0] opt_s;
	logic       rsw_s;
	assign mon_s = pins_s[0];
	assign opt_s = pins_s[6:1];
	assign rsw_s = pins_s[7];

	////////////////////////////////////////////////////////////////////////////
	// ahb-lite register slave
	logic                  mode_edge_q, mode_edge_d;   // 1: rising edge recognition
	logic                  srel_en_q, srel_en_d;       // static release present
	logic                  ind_en_q, ind_en_d;         // indication present
	logic [CTRL_NIN_W-1:0] nin_q, nin_d;               // gating input count
	logic                  wr_pend_q, wr_pend_d;       // write data phase pending
	logic [7:0]            wr_addr_q, wr_addr_d;
	logic [31:0]           rdata_q, rdata_d;
	logic                  addr_ok;
	srg_state_e            st_q, st_d;                 // reset recognition state, read back as armed

	// a transfer of any size taken at this edge
	assign addr_ok = hsel && hready && htrans[1];

	// number of gating inputs, clamped to the legal range
	function automatic logic [3:0] clamp_nin(input logic [3:0] v);
		if (v < 4'(NUM_IN_MIN))
			clamp_nin = 4'(NUM_IN_MIN);
		else if (v > 4'(NUM_IN_MAX))
			clamp_nin = 4'(NUM_IN_MAX);
		else
			clamp_nin = v;
	endfunction : clamp_nin

	// next register values and read data
	always_comb begin
		mode_edge_d = mode_edge_q;
		srel_en_d   = srel_en_q;
		ind_en_d    = ind_en_q;
		nin_d       = nin_q;
		wr_pend_d   = addr_ok && hwrite;
		wr_addr_d   = haddr;
		rdata_d     = rdata_q;
		// write lands in the data phase
		if (wr_pend_q && wr_addr_q == ADDR_CTRL) begin
			mode_edge_d = hwdata[CTRL_EDGE_BIT];
			srel_en_d   = hwdata[CTRL_SREL_BIT];
			ind_en_d    = hwdata[CTRL_IND_BIT];
			nin_d       = clamp_nin(hwdata[CTRL_NIN_LSB +: CTRL_NIN_W]);
		end
		// read data captured in the address phase, unmapped reads zero
		if (addr_ok && !hwrite) begin
			rdata_d = '0;
			case (haddr)
				ADDR_CTRL: begin
					rdata_d[CTRL_EDGE_BIT]                 = mode_edge_q;
					rdata_d[CTRL_SREL_BIT]                 = srel_en_q;
					rdata_d[CTRL_IND_BIT]                  = ind_en_q;
					rdata_d[CTRL_NIN_LSB +: CTRL_NIN_W]    = nin_q;
				end
				ADDR_STATUS: begin
					rdata_d[STAT_EN_BIT]                   = out_en;
					rdata_d[STAT_SREL_BIT]                 = static_rel;
					rdata_d[STAT_IND_BIT]                  = rst_req_ind;
					rdata_d[STAT_ARM_BIT]                  = (st_q == SRG_HIGH_SEEN);
					rdata_d[STAT_IN_LSB +: 8]              = pins_s;
				end
				default: rdata_d = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// gating logic
	logic                   rsw_prev_q;       // reset switch last cycle
	logic                   all_on;           // monitored and enabled inputs on
	logic [5:0]             opt_mask;
	logic [IND_CNT_W-1:0]   blink_cnt_q, blink_cnt_d;
	logic                   blink_q, blink_d;
	logic                   en_d, srel_d, ind_d;

	// optional input k counts when nin exceeds k+2
	always_comb begin
		for (int k = 0; k < OPT_IN_MAX; k++)
			opt_mask[k] = (nin_q > 4'(k + 2));
	end

	// monitored input and every enabled optional input on
	assign all_on = mon_s && ((opt_s | ~opt_mask) == 6'h3f);

	// state, blinker and outputs; the restart variant is this same logic
	always_comb begin
		st_d        = st_q;
		blink_cnt_d = blink_cnt_q;
		blink_d     = blink_q;
		case (st_q)
			SRG_IDLE: begin
				// needs a rise of rsw_s; a switch held through reset still counts once pins_s leaves its reset zero
				if (all_on && rsw_s && !rsw_prev_q) begin
					if (mode_edge_q)
						st_d = SRG_ENABLED;
					else
						st_d = SRG_HIGH_SEEN;
				end
			end
			SRG_HIGH_SEEN: begin
				if (!all_on)
					st_d = SRG_IDLE;
				else if (mode_edge_q)
					st_d = SRG_IDLE; // mode changed mid pulse, start over
				else if (!rsw_s)
					st_d = SRG_ENABLED;
			end
			SRG_ENABLED: begin
				if (!all_on)
					st_d = SRG_IDLE;
			end
			default: st_d = SRG_IDLE;
		endcase
		// free 1 hz blinker restarted whenever not needed
		if (all_on && st_q != SRG_ENABLED) begin
			if (blink_cnt_q == IND_CNT_W'(IND_HALF_CYC - 1)) begin
				blink_cnt_d = '0;
				blink_d     = ~blink_q;
			end else begin
				blink_cnt_d = blink_cnt_q + 1'b1;
			end
		end else begin
			blink_cnt_d = '0;
			blink_d     = 1'b1;
		end
		en_d   = (st_d == SRG_ENABLED);
		srel_d = srel_en_q && all_on;
		if (!ind_en_q)
			ind_d = 1'b0;
		else if (!mode_edge_q && st_q != SRG_ENABLED && rsw_s)
			ind_d = 1'b1;
		else
			ind_d = all_on && st_d != SRG_ENABLED && blink_d;
	end

	////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mode_edge_q <= CTRL_EDGE_RST;
			srel_en_q   <= CTRL_SREL_RST;
			ind_en_q    <= CTRL_IND_RST;
			nin_q       <= CTRL_NIN_RST;
			wr_pend_q   <= 1'b0;
			wr_addr_q   <= 8'h00;
			rdata_q     <= 32'h0000_0000;
			st_q        <= SRG_IDLE;
			rsw_prev_q  <= 1'b1; // pins_s resets low, so a held switch still rises later
			blink_cnt_q <= '0;
			blink_q     <= 1'b1;
			out_en      <= 1'b0;
			static_rel  <= 1'b0;
			rst_req_ind <= 1'b0;
		end else begin
			mode_edge_q <= mode_edge_d;
			srel_en_q   <= srel_en_d;
			ind_en_q    <= ind_en_d;
			nin_q       <= nin_d;
			wr_pend_q   <= wr_pend_d;
			wr_addr_q   <= wr_addr_d;
			rdata_q     <= rdata_d;
			st_q        <= st_d;
			rsw_prev_q  <= rsw_s;
			blink_cnt_q <= blink_cnt_d;
			blink_q     <= blink_d;
			out_en      <= en_d;
			static_rel  <= srel_d;
			rst_req_ind <= ind_d;
		end
	end

	// zero wait states, always okay
	assign hrdata    = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

endmodule : srg_gate

// >>> dv/srg_gate_props.sv
`timescale 1ns/1ps
module srg_gate_props (
	// clock, reset
	input wire logic        mclk,
	input wire logic        rstn,
	// pins
	input wire logic        mon_in,
	input wire logic        rst_sw,
	input wire logic        out_en,
	input wire logic        static_rel,
	input wire logic        rst_req_ind,
	// bus
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp
);
	logic [3:0] age_q, age_d; // cycles since switch moved
	logic       sw_q, sw_d, rd_q, rd_d;
	// age saturates so an old press never counts
	always_comb begin
		age_d = (rst_sw != sw_q) ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
		sw_d = rst_sw;
		rd_d = hsel && hready && htrans[1] && !hwrite;
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			age_q <= 4'hf;
			sw_q <= 1'b0;
			rd_q <= 1'b0;
		end else begin
			age_q <= age_d;
			sw_q <= sw_d;
			rd_q <= rd_d;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	a_bus_okay: assert property (hreadyout && !hresp) else $error("bad bus answer");
	a_en_low: assert property (!mon_in [*6] |-> !out_en) else $error("enable with input off");
	a_rel_low: assert property (!mon_in [*6] |-> !static_rel) else $error("release with input off");
	a_ind_low: assert property (!mon_in [*6] |-> !rst_req_ind) else $error("indication with input off");
	a_en_fresh: assert property ($rose(out_en) |-> age_q < 4'h9) else $error("enable without press");
	a_rise_quiet: assert property ($rose(static_rel) |-> !out_en) else $error("auto enable");
	a_ind_off_en: assert property (out_en && $past(out_en) |-> !rst_req_ind) else $error("ind while on");
	a_rdata_hold: assert property (!rd_q |-> $stable(hrdata)) else $error("read data moved");
	c_en: cover property ($rose(out_en));
	c_rel: cover property ($rose(static_rel));
	c_ind: cover property ($rose(rst_req_ind));
endmodule : srg_gate_props
bind srg_gate srg_gate_props u_srg_gate_props (.mclk(mclk), .rstn(rstn), .mon_in(mon_in), .rst_sw(rst_sw),
	.out_en(out_en), .static_rel(static_rel), .rst_req_ind(rst_req_ind), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// >>> dv/srg_pins.sv
`timescale 1ns/1ps
// safety devices and operator switch
module srg_pins (
	// clock
	input wire logic  mclk,
	// pins
	output logic       mon_in,
	output logic [5:0] opt_in,
	output logic       rst_sw
);
	initial begin
		mon_in = 1'b0;
		opt_in = 6'h00;
		rst_sw = 1'b0;
	end
	// devices change just after an edge
	task put(input logic [6:0] v);
		@(posedge mclk);
		{opt_in, mon_in} <= v;
	endtask : put
	task sw(input logic v);
		@(posedge mclk);
		rst_sw <= v;
	endtask : sw
endmodule : srg_pins

// >>> dv/test_safety_reset_restart_gate.sv
`timescale 1ns/1ps
module test_safety_reset_restart_gate;
	import srg_pkg::*;
	logic        mclk, rstn, hsel, hwrite, mon_in, rst_sw, out_en, sr, ind, hready, hresp;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [5:0]  opt_in;
	logic [31:0] hwdata, hrdata, r;
	int          err_total, checks, tick;
	srg_pins u_srg_pins (.mclk(mclk), .mon_in(mon_in), .opt_in(opt_in), .rst_sw(rst_sw));
	srg_gate u_srg_gate (.mclk(mclk), .rstn(rstn), .mon_in(mon_in), .opt_in(opt_in), .rst_sw(rst_sw),
		.out_en(out_en), .static_rel(sr), .rst_req_ind(ind), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task finish_test;
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	// hang guard
	always @(posedge mclk) begin
		tick <= tick + 1;
		if (tick == 5000) begin
			err_total++;
			finish_test();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// wait n edges, let updates land, then compare outputs {ind,rel,en}
	task out(input int n, input logic [2:0] e);
		repeat (n) @(posedge mclk);
		#1 chk({29'h0, ind, sr, out_en}, {29'h0, e});
	endtask : out
	// one ahb-lite single word transfer
	task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
		do @(posedge mclk); while (hready !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		do @(posedge mclk); while (hready !== 1'b1);
		r = hrdata;
	endtask : xf
	////////////////////////////////////////////////////////////////
	task t_regs;
		xf(0, ADDR_CTRL, 0);
		chk(r, 32'h20);
		xf(0, 8'h08, 0);
		chk(r, 0);
		u_srg_pins.put(7'h01);
		out(8, 3'h0);
	endtask : t_regs
	task t_lhl;
		xf(1, ADDR_CTRL, 32'h26);
		out(8, 3'h6);
		u_srg_pins.sw(1);
		out(8, 3'h6);
		// armed, switch and monitored input seen in the status word
		xf(0, ADDR_STATUS, 0);
		chk(r, 32'h810e);
		u_srg_pins.sw(0);
		out(8, 3'h3);
		u_srg_pins.put(0);
		out(8, 3'h0);
		u_srg_pins.put(1);
		out(8, 3'h6);
		u_srg_pins.sw(1);
		u_srg_pins.sw(0);
		out(8, 3'h3);
		rstn <= 1'b0;
		out(2, 3'h0);
		rstn <= 1'b1;
		out(8, 3'h0);
	endtask : t_lhl
	task t_edge;
		xf(1, ADDR_CTRL, 32'h37);
		xf(0, ADDR_CTRL, 0);
		chk(r, 32'h37);
		out(8, 3'h0);
		u_srg_pins.sw(1);
		out(8, 3'h0);
		u_srg_pins.put(7'h03);
		out(8, 3'h6);
		u_srg_pins.sw(0);
		out(8, 3'h6);
		u_srg_pins.sw(1);
		out(8, 3'h3);
		u_srg_pins.put(7'h01);
		out(8, 3'h0);
		u_srg_pins.sw(0);
	endtask : t_edge
	initial begin
		{rstn, hsel, hwrite, haddr, htrans, hwdata} = '0;
		{err_total, checks, tick} = '0;
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		t_regs();
		t_lhl();
		t_edge();
		finish_test();
	end
endmodule : test_safety_reset_restart_gate
